/* File: design/dpl_pkg.sv */
// Shared constants and types for the digital phase loop core
package dpl_pkg;
  // Register byte offsets
  localparam logic [11:0] DPL_REG_CTRL = 12'h000;
  localparam logic [11:0] DPL_REG_STATUS = 12'h004;
  localparam logic [11:0] DPL_REG_EVENTS = 12'h008;
  // Control fields
  localparam int DPL_CTRL_MSEL_LSB = 0;
  localparam int DPL_MSEL_W = 4;
  localparam logic [3:0] DPL_MSEL_RESET = 4'h0;
  localparam logic [3:0] DPL_MSEL_OFF = 4'h0;
  // Status fields
  localparam int DPL_ST_XOR_BIT = 0;
  localparam int DPL_ST_EDGE_BIT = 1;
  localparam int DPL_ST_IDOUT_BIT = 2;
  localparam int DPL_ST_INHIBIT_BIT = 3;
  localparam int DPL_ST_DIR_BIT = 4;
  // Event counters: carries in low half, borrows in high half
  localparam int DPL_EVT_W = 16;
  localparam int DPL_EVT_BORROW_LSB = 16;
  // Up/down counter width: longest modulo is two to the 17th
  localparam int DPL_CNT_W = 17;
  localparam int DPL_MSEL_EXP_OFS = 2;
  // Extra or skipped toggles per inserted or deleted output pulse
  localparam logic [2:0] DPL_TOGGLES_PER_PULSE = 3'h2;
  localparam logic [2:0] DPL_TOGGLES_MAX = 3'h6;

  // Terminal count of the up/down counter for a modulo select code
  function automatic logic [DPL_CNT_W-1:0] dpl_mask(input logic [3:0] msel);
    logic [DPL_CNT_W:0] one;
    one = {{DPL_CNT_W{1'b0}}, 1'b1};
    dpl_mask = DPL_CNT_W'((one << (msel + DPL_MSEL_EXP_OFS)) - one);
  endfunction
endpackage

/* File: design/dpl_kcnt_if.sv */
// Link between the loop core and its up/down counter
`timescale 1ns/100ps
`default_nettype none
interface dpl_kcnt_if;
  import dpl_pkg::*;
  logic step;
  logic up;
  logic enable;
  logic [3:0] msel;
  logic carry;
  logic borrow;
  logic carry_evt;
  logic borrow_evt;
  logic [DPL_CNT_W-1:0] count;
  modport ctl (output step, output up, output enable, output msel,
    input carry, input borrow, input carry_evt, input borrow_evt,
    input count);
  modport cnt (input step, input up, input enable, input msel,
    output carry, output borrow, output carry_evt, output borrow_evt,
    output count);
endinterface
`default_nettype wire

/* File: design/dpl_kcounter.sv */
// Programmable-modulo up/down counter with carry and borrow pulses
`timescale 1ns/100ps
`default_nettype none
module dpl_kcounter
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dpl_kcnt_if.cnt kc
);
  logic [DPL_CNT_W-1:0] count_q;
  logic carry_q;
  logic borrow_q;
  logic carry_evt_q;
  logic borrow_evt_q;
  logic inhibit;
  logic wrap_up;
  logic wrap_dn;

  // Code zero stops counting and all pulses
  assign inhibit = (kc.msel == DPL_MSEL_OFF);
  assign wrap_up = kc.up && (count_q == dpl_mask(kc.msel));
  assign wrap_dn = !kc.up && (count_q == '0);

  // Count advances only on a counter clock rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (kc.step) begin
      if (inhibit || !kc.enable) begin
        count_q <= count_q;
      end else if (wrap_up) begin
        count_q <= '0;
      end else if (wrap_dn) begin
        count_q <= dpl_mask(kc.msel);
      end else if (kc.up) begin
        count_q <= count_q + 1'b1;
      end else begin
        count_q <= (count_q - 1'b1) & dpl_mask(kc.msel);
      end
    end
  end

  // Pulses stand for one whole counter clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      borrow_q <= 1'b0;
      carry_evt_q <= 1'b0;
      borrow_evt_q <= 1'b0;
    end else begin
      carry_evt_q <= kc.step && kc.enable && !inhibit && wrap_up;
      borrow_evt_q <= kc.step && kc.enable && !inhibit && wrap_dn;
      if (kc.step) begin
        carry_q <= kc.enable && !inhibit && wrap_up;
        borrow_q <= kc.enable && !inhibit && wrap_dn;
      end
    end
  end

  assign kc.count = count_q;
  assign kc.carry = carry_q;
  assign kc.borrow = borrow_q;
  assign kc.carry_evt = carry_evt_q;
  assign kc.borrow_evt = borrow_evt_q;
endmodule
`default_nettype wire

/* File: design/dpl_core.sv */
// Digital phase loop core: detectors, counter control, inc/dec stage, APB
//
// Summary of operation
// - Four select bits code n gives counter modulo two to the n+2.
// - Select code zero inhibits the counter; no carry or borrow.
// - XOR detector output high exactly when its phase inputs differ.
// - Edge detector: reference fall sets, feedback fall clears.
// - Both detectors give square waves of equal halves at zero error.
// - XOR detector gain four; high throughout at quarter-cycle error.
// - XOR detector zero error at quarter-cycle input separation.
// - Edge detector gain two; high throughout at half-cycle error.
// - Edge detector zero error at half-cycle input separation.
// - Counter advances on its own counter clock rising edges.
// - Counter wrapping upward emits a carry pulse.
// - Counter wrapping downward emits a borrow pulse.
// - Without pulses, inc/dec output is half its clock frequency.
// - Each carry inserts one output pulse; each borrow deletes one.
// - Direction and enable sampled at counter clock rising edge.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module dpl_core
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_phase_input,
  input wire logic feedback_phase_input,
  input wire logic counter_clock,
  input wire logic incdec_clock,
  input wire logic count_up,
  input wire logic counter_enable,
  output logic xor_detector_output,
  output logic edge_detector_output,
  output logic incdec_output,
  output logic counter_carry,
  output logic counter_borrow
);
  // Counter control and its pulses travel together in one bundle
  dpl_kcnt_if kc ();

  // Two-stage synchronisers; stage one feeds only stage two
  // Each pin goes through its own pair; no multi-bit word crosses here.
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic ref_last_q;
  logic fb_last_q;
  logic kclk_last_q;
  logic idclk_last_q;

  // Synchronised pin levels
  logic ref_s;
  logic fb_s;
  logic kclk_s;
  logic idclk_s;
  logic up_s;
  logic en_s;

  // Every pin is sampled as data. Clock pins must keep each level for
  // more than one pclk cycle or an edge is lost; that sets their limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= {counter_enable, count_up, incdec_clock, counter_clock,
        feedback_phase_input, reference_phase_input};
      sync_q <= meta_q;
    end
  end

  assign ref_s = sync_q[0];
  assign fb_s = sync_q[1];
  assign kclk_s = sync_q[2];
  assign idclk_s = sync_q[3];
  assign up_s = sync_q[4];
  assign en_s = sync_q[5];

  // Last values of synchronised levels, for edge detection
  // These reset low, like the synchroniser stages ahead of them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_last_q <= 1'b0;
      fb_last_q <= 1'b0;
      kclk_last_q <= 1'b0;
      idclk_last_q <= 1'b0;
    end else begin
      ref_last_q <= ref_s;
      fb_last_q <= fb_s;
      kclk_last_q <= kclk_s;
      idclk_last_q <= idclk_s;
    end
  end

  // One-cycle strobes from the synchronised levels. History flops reset
  // low; a counter clock pin that idles high therefore gives one false
  // step after reset, so hold it low until reset is released.
  logic ref_fall;
  logic fb_fall;
  logic kclk_rise;
  logic id_rise;
  logic id_fall;
  assign ref_fall = ref_last_q && !ref_s;
  assign fb_fall = fb_last_q && !fb_s;
  assign kclk_rise = !kclk_last_q && kclk_s;
  assign id_rise = !idclk_last_q && idclk_s;
  assign id_fall = idclk_last_q && !idclk_s;

  // Phase detectors. Inputs a quarter cycle apart give the XOR output
  // equal halves; half a cycle apart does the same for the edge output.
  // Both pass the same synchroniser depth, so relative phase is kept.
  // Gain: quarter-cycle error saturates the XOR output, half-cycle the
  // edge output, as both run on the same sampled levels.
  logic xor_q;
  logic edge_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xor_q <= 1'b0;
    end else begin
      xor_q <= ref_s ^ fb_s;
    end
  end

  // Edge detector ignores rising edges; reference wins a tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_q <= 1'b0;
    end else if (ref_fall) begin
      edge_q <= 1'b1;
    end else if (fb_fall) begin
      edge_q <= 1'b0;
    end
  end

  assign xor_detector_output = xor_q;
  assign edge_detector_output = edge_q;

  // Modulo select register, writable at any time to retune bandwidth
  logic [3:0] msel_q;

  // Direction and enable are taken at the counter clock rising edge
  assign kc.step = kclk_rise;
  assign kc.up = up_s;
  assign kc.enable = en_s;
  assign kc.msel = msel_q;

  dpl_kcounter u_kcounter (
    .pclk(pclk),
    .presetn(presetn),
    .kc(kc)
  );

  // Pulses leave straight from the counter's flops, never from gates
  assign counter_carry = kc.carry;
  assign counter_borrow = kc.borrow;

  // Inc/dec stage. Normally toggles on each clock rise, giving half the
  // clock rate. A carry adds toggles on clock falls (one extra pulse);
  // a borrow swallows toggles on clock rises (one pulse lost).
  // Pending work is held in counters so no event is dropped when
  // one arrives while an earlier one is still being applied, unless
  // three pulses are already pending.
  // Inserts and deletes queue separately, so a carry and a borrow that
  // arrive close together both act and cancel in effect.
  logic [2:0] add_left_q;
  logic [2:0] del_left_q;
  logic idout_q;

  // Saturating add of one pulse worth of toggles
  // Work is lost only if a fourth pulse arrives before the clock has fully served the first of three
  function automatic logic [2:0] dpl_queue(input logic [2:0] cur);
    if (cur > DPL_TOGGLES_MAX - DPL_TOGGLES_PER_PULSE) begin
      dpl_queue = DPL_TOGGLES_MAX;
    end else begin
      dpl_queue = cur + DPL_TOGGLES_PER_PULSE;
    end
  endfunction

  // Pending inserts: a new carry and the decrement it meets both take effect
  // Each inserted pulse costs two falling edges of the inc/dec clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_left_q <= 3'h0;
    end else if (kc.carry_evt) begin
      add_left_q <= dpl_queue(add_left_q - 3'(id_fall && add_left_q != 3'h0));
    end else if (id_fall && add_left_q != 3'h0) begin
      add_left_q <= add_left_q - 3'h1;
    end
  end

  // Pending deletes: a new borrow and the decrement it meets both take effect
  // Each deleted pulse swallows two rising edges of the inc/dec clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      del_left_q <= 3'h0;
    end else if (kc.borrow_evt) begin
      del_left_q <= dpl_queue(del_left_q - 3'(id_rise && del_left_q != 3'h0));
    end else if (id_rise && del_left_q != 3'h0) begin
      del_left_q <= del_left_q - 3'h1;
    end
  end

  // Output toggle flip-flop
  // A rise with deletes pending is swallowed; falls only ever add toggles,
  // so an insert and a delete never fight over one edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idout_q <= 1'b0;
    end else if (id_rise && del_left_q == 3'h0) begin
      idout_q <= !idout_q;
    end else if (id_fall && add_left_q != 3'h0) begin
      idout_q <= !idout_q;
    end else if (id_rise) begin
      idout_q <= idout_q;
    end
  end

  assign incdec_output = idout_q;

  // Carry and borrow tallies for software, wrapping at full scale
  // They are for observation only and never feed back into the loop.
  logic [DPL_EVT_W-1:0] carries_q;
  logic [DPL_EVT_W-1:0] borrows_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carries_q <= '0;
      borrows_q <= '0;
    end else begin
      if (kc.carry_evt) begin
        carries_q <= carries_q + 1'b1;
      end
      if (kc.borrow_evt) begin
        borrows_q <= borrows_q + 1'b1;
      end
    end
  end

  // APB decode; zero wait states, unmapped addresses give an error
  // Limitation: no byte strobes; every write replaces a whole word.
  logic hit_ctrl;
  logic hit_status;
  logic hit_events;
  logic mapped;
  logic wr_ctrl;
  assign hit_ctrl = (paddr == DPL_REG_CTRL);
  assign hit_status = (paddr == DPL_REG_STATUS);
  assign hit_events = (paddr == DPL_REG_EVENTS);
  assign mapped = hit_ctrl || hit_status || hit_events;
  assign wr_ctrl = psel && penable && pwrite && hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Control register write
  // A select change keeps the count: counting up, a value above the new
  // terminal count runs on to full scale before it wraps; counting down masks it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msel_q <= DPL_MSEL_RESET;
    end else if (wr_ctrl) begin
      msel_q <= pwdata[DPL_CTRL_MSEL_LSB +: DPL_MSEL_W];
    end
  end

  // Read data is captured in the setup cycle so it comes from a register
  // Unmapped reads return zero alongside the error response.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[DPL_CTRL_MSEL_LSB +: DPL_MSEL_W] = msel_q;
    end else if (hit_status) begin
      rd_mux[DPL_ST_XOR_BIT] = xor_q;
      rd_mux[DPL_ST_EDGE_BIT] = edge_q;
      rd_mux[DPL_ST_IDOUT_BIT] = idout_q;
      rd_mux[DPL_ST_INHIBIT_BIT] = (msel_q == DPL_MSEL_OFF);
      rd_mux[DPL_ST_DIR_BIT] = up_s;
    end else if (hit_events) begin
      rd_mux[0 +: DPL_EVT_W] = carries_q;
      rd_mux[DPL_EVT_BORROW_LSB +: DPL_EVT_W] = borrows_q;
    end
  end

  // Holding read data in a flop keeps pin noise off the bus
  logic [31:0] prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;
endmodule
`default_nettype wire

/* File: dv/dpl_divn_model.sv */
// Outside divide-by-N counter closing the loop
`timescale 1ns/100ps
`default_nettype none
module dpl_divn_model #(
  parameter int N = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic divide_input,
  output logic loop_output
);
  logic last_q;
  int cnt_q;
  // Count input rises modulo N; first half of the count drives high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      last_q <= divide_input;
      if (divide_input && !last_q)
        cnt_q <= (cnt_q + 1) % N;
    end
  end
  assign loop_output = (cnt_q < N / 2);
endmodule
`default_nettype wire

/* File: dv/dpl_core_properties.sv */
// Port assertions for the loop core
`timescale 1ns/100ps
`default_nettype none
module dpl_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reference_phase_input,
  input wire logic feedback_phase_input,
  input wire logic counter_clock,
  input wire logic incdec_clock,
  input wire logic xor_detector_output,
  input wire logic edge_detector_output,
  input wire logic incdec_output,
  input wire logic counter_carry,
  input wire logic counter_borrow
);
  logic kclk_q;
  logic iclk_q;
  logic [3:0] kage_q;
  logic [3:0] iage_q;
  // Ages since clock pin edges; saturate so idle spans never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kclk_q <= 1'b0;
      iclk_q <= 1'b0;
      kage_q <= 4'hF;
      iage_q <= 4'hF;
    end else begin
      kclk_q <= counter_clock;
      iclk_q <= incdec_clock;
      kage_q <= (counter_clock && !kclk_q) ? 4'h0 :
        kage_q + {3'h0, kage_q != 4'hF};
      iage_q <= (incdec_clock != iclk_q) ? 4'h0 :
        iage_q + {3'h0, iage_q != 4'hF};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_xor_match: assert property (
    ($stable(reference_phase_input) && $stable(feedback_phase_input))[*6]
    |-> xor_detector_output == (reference_phase_input ^ feedback_phase_input))
    else $error("xor output wrong");
  a_edge_sets: assert property (
    $fell(reference_phase_input) ##1 $stable(feedback_phase_input)[*4]
    |-> edge_detector_output) else $error("edge output not set");
  a_edge_clears: assert property (
    ($fell(feedback_phase_input) && !$fell(reference_phase_input)) ##1
    $stable(reference_phase_input)[*4] |-> !edge_detector_output)
    else $error("edge output not cleared");
  a_edge_holds: assert property (
    (!$fell(reference_phase_input) && !$fell(feedback_phase_input))[*6]
    |-> $stable(edge_detector_output)) else $error("edge output moved");
  a_carry_cause: assert property (
    $rose(counter_carry) |-> kage_q inside {[4'h2:4'h6]})
    else $error("carry without counter clock");
  a_borrow_cause: assert property (
    $rose(counter_borrow) |-> kage_q inside {[4'h2:4'h6]})
    else $error("borrow without counter clock");
  a_pulse_length: assert property (
    ($fell(counter_carry) || $fell(counter_borrow))
    |-> kage_q inside {[4'h2:4'h6]}) else $error("pulse ended early");
  a_incdec_cause: assert property (
    $changed(incdec_output) |-> iage_q inside {[4'h1:4'h6]})
    else $error("incdec output moved alone");
endmodule
bind dpl_core dpl_core_chk dpl_core_chk_i (.*);
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the loop core
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dpl_pkg::*;
  localparam logic [2:0] EDGE_STEPS [5] = '{3'h3, 3'h7, 3'h4, 3'h6, 3'h1};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic reference_phase_input = 1'b0;
  logic tb_fb = 1'b0;
  logic use_model = 1'b0;
  logic counter_clock = 1'b0;
  logic incdec_clock = 1'b0;
  logic count_up = 1'b0;
  logic counter_enable = 1'b0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, err, model_fb, id_prev;
  logic xor_detector_output, edge_detector_output, incdec_output;
  logic counter_carry, counter_borrow;
  int miscompares = 0;
  int n_compared = 0;
  int n_rise = 0;
  int r0;
  wire logic feedback_phase_input = use_model ? model_fb : tb_fb;
  dpl_core dpl_core_i (.*);
  dpl_divn_model dpl_divn_model_i (.pclk(pclk), .presetn(presetn),
    .divide_input(incdec_output), .loop_output(model_fb));
  always #5 pclk = !pclk;
  // Count output rises to measure inserted and deleted pulses
  always @(posedge pclk) begin
    id_prev <= incdec_output;
    if (incdec_output === 1'b1 && id_prev === 1'b0)
      n_rise <= n_rise + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Full periods of a pin clock, four pclk per half so syncs keep up
  task automatic tick(input logic k, input int n);
    repeat (2 * n) begin
      if (k)
        counter_clock <= !counter_clock;
      else
        incdec_clock <= !incdec_clock;
      repeat (4) @(posedge pclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("events_rst", q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, DPL_REG_CTRL, i);
      apb(1'b0, DPL_REG_CTRL, 32'h0);
      chk("msel", q, i);
      apb(1'b0, DPL_REG_STATUS, 32'h0);
      chk("inhibit", q[DPL_ST_INHIBIT_BIT], i == 0);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {reference_phase_input, tb_fb} <= 2'(i);
      repeat (6) @(posedge pclk);
      chk("xor", xor_detector_output, ^(2'(i)));
    end
    for (int i = 0; i < 5; i++) begin
      {reference_phase_input, tb_fb} <= EDGE_STEPS[i][2:1];
      repeat (6) @(posedge pclk);
      chk("edge", edge_detector_output, EDGE_STEPS[i][0]);
    end
    use_model <= 1'b1;
    r0 = n_rise;
    tick(1'b0, 8);
    chk("idle_rises", n_rise - r0, 4);
    apb(1'b1, DPL_REG_CTRL, 32'h1);
    {count_up, counter_enable} <= 2'h3;
    repeat (4) @(posedge pclk);
    tick(1'b1, 8);
    r0 = n_rise;
    tick(1'b0, 8);
    chk("carry_rises", n_rise - r0, 5);
    count_up <= 1'b0;
    repeat (4) @(posedge pclk);
    tick(1'b1, 1);
    chk("borrow_out", counter_borrow, 1'b1);
    chk("carry_ended", counter_carry, 1'b0);
    r0 = n_rise;
    tick(1'b0, 8);
    chk("borrow_rises", n_rise - r0, 3);
    tick(1'b1, 8);
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("reload", q, 32'h0002_0001);
    apb(1'b1, DPL_REG_CTRL, 32'h2);
    count_up <= 1'b1;
    repeat (4) @(posedge pclk);
    tick(1'b1, 8);
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("mod16_short", q, 32'h0002_0001);
    tick(1'b1, 1);
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("mod16_wrap", q, 32'h0002_0002);
    chk("carry_out", counter_carry, 1'b1);
    apb(1'b1, DPL_REG_CTRL, 32'h0);
    tick(1'b1, 20);
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("inhibited", q, 32'h0002_0002);
    apb(1'b1, DPL_REG_CTRL, 32'h1);
    counter_enable <= 1'b0;
    repeat (4) @(posedge pclk);
    tick(1'b1, 20);
    apb(1'b0, DPL_REG_EVENTS, 32'h0);
    chk("disabled", q, 32'h0002_0002);
    close_out;
  end
  // Cut a hang short; the sequence needs only about a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
